// File: verilog/xor_acc_pkg.sv
// constants for the accumulator/file exclusive-or datapath
`default_nettype none
package xor_acc_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int OPCODE_W = 16;
	localparam int BANK_W = 4;
	// opcode layout: 0001 10da ffff ffff
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 10;
	localparam logic [5:0] OPC_XOR_FILE = 6'h06;
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	localparam int FIELD_HI = 7;
	localparam int FIELD_LO = 0;
	// f values up to this limit are indexed when a = 0 and extension is on
	localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
	// access bank low half splits at the same point
	localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [11:0] ADDR_RESET = 12'h000;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} xor_state_t;
endpackage
`default_nettype wire

// File: verilog/xor_accumulator_with_file.sv
// exclusive-or of the accumulator with a data-memory register
`default_nettype none
// Operation
// RQ1: result is accumulator XOR addressed register
// RQ2: opcode carries 8-bit f, d, a
// RQ3: a=0 with extension uses indexed addressing
// RQ4: indexing only when f at most 95
// RQ5: d selects destination; N and Z updated
module xor_accumulator_with_file (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic EXEC,
	input wire logic [xor_acc_pkg::OPCODE_W-1:0] OPCODE,
	input wire logic XINST_EN,
	input wire logic [xor_acc_pkg::BANK_W-1:0] BANK_SELECT_REG,
	input wire logic [xor_acc_pkg::ADDR_W-1:0] INDEX_BASE,
	input wire logic ACC_LOAD,
	input wire logic [xor_acc_pkg::DATA_W-1:0] ACC_IN,
	input wire logic [xor_acc_pkg::DATA_W-1:0] MEM_RDATA,
	output logic [xor_acc_pkg::ADDR_W-1:0] MEM_ADDR,
	output logic MEM_RD,
	output logic MEM_WR,
	output logic [xor_acc_pkg::DATA_W-1:0] MEM_WDATA,
	output logic [xor_acc_pkg::DATA_W-1:0] ACC,
	output logic FLAG_N,
	output logic FLAG_Z,
	output logic BUSY,
	output logic DONE
);
	import xor_acc_pkg::*;

	// shared window test: indexed mode and access bank split alike
	function automatic logic in_low_window(
		input logic [7:0] value,
		input logic [7:0] limit
	);
		in_low_window = (value <= limit);
	endfunction

	// sequencer state
	xor_state_t state;
	xor_state_t next_state;

	// operands captured at accept and at the end of the read
	logic dest;
	logic [DATA_W-1:0] result;

	// phase strobes; each compares the whole one-hot state code
	wire logic in_idle = (state == ST_IDLE);
	wire logic in_read = (state == ST_READ);
	wire logic in_write = (state == ST_WRITE);

	// opcode field decode
	wire logic [7:0] field = OPCODE[FIELD_HI:FIELD_LO]; // [RQ2]
	wire logic dest_sel = OPCODE[DEST_BIT]; // [RQ2]
	wire logic access_sel = OPCODE[ACCESS_BIT]; // [RQ2]
	wire logic is_xor_op = (OPCODE[OPC_HI:OPC_LO] == OPC_XOR_FILE);

	// requests while busy are dropped silently, callers watch busy
	wire logic accept = EXEC && is_xor_op && in_idle;

	// window tests for the two low-address interpretations
	wire logic field_low_idx = in_low_window(field, INDEXED_LIMIT); // [RQ4]
	wire logic field_low_acc = in_low_window(field, ACCESS_SPLIT);

	// operand address resolution; indexed wins only in the low window
	wire logic use_indexed = !access_sel && XINST_EN // [RQ3]
		&& field_low_idx; // [RQ4]
	wire logic [ADDR_W-1:0] field_ext = {{(ADDR_W-8){1'b0}}, field};
	wire logic [ADDR_W-1:0] indexed_addr = INDEX_BASE + field_ext; // [RQ3]
	wire logic [ADDR_W-1:0] access_addr = field_low_acc ?
		field_ext : {ACCESS_HIGH_BANK, field};
	wire logic [ADDR_W-1:0] banked_addr = {BANK_SELECT_REG, field};
	wire logic [ADDR_W-1:0] direct_addr = access_sel ?
		banked_addr : access_addr;
	wire logic [ADDR_W-1:0] operand_addr = use_indexed ?
		indexed_addr : direct_addr; // [RQ3]

	// datapath: one gate per bit; memory data only counts in the
	// read cycle, so it is taken at that cycle's closing edge
	wire logic [DATA_W-1:0] xor_value;
	genvar b;
	generate
		for (b = 0; b < DATA_W; b++) begin : g_xor_bit
			assign xor_value[b] = ACC[b] ^ MEM_RDATA[b]; // [RQ1]
		end
	endgenerate

	// destination steering and flag values of the captured result
	wire logic write_acc = in_write && !dest; // [RQ5]
	wire logic write_file = in_write && dest; // [RQ5]
	wire logic result_neg = result[DATA_W-1]; // [RQ5]
	wire logic result_zero = (result == '0); // [RQ5]

	// a load in the write cycle is lost, even when the file is the destination
	wire logic acc_update = write_acc || (ACC_LOAD && !in_write);
	wire logic [DATA_W-1:0] next_acc = write_acc ? result : ACC_IN;

	// sequencer: idle, read register, write destination
	always_comb begin
		next_state = ST_IDLE;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = ST_READ;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_READ: begin
				next_state = ST_WRITE;
			end
			ST_WRITE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// read strobe: one cycle, right after accept
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			MEM_RD <= 1'b0;
		end else begin
			MEM_RD <= accept;
		end
	end

	// operand address held until the next accepted request
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			MEM_ADDR <= ADDR_RESET;
		end else if (accept) begin
			MEM_ADDR <= operand_addr; // [RQ3] [RQ4]
		end
	end

	// destination choice latched together with the address
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			dest <= 1'b0;
		end else if (accept) begin
			dest <= dest_sel; // [RQ5]
		end
	end

	// result capture at the end of the read cycle
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			result <= ACC_RESET;
		end else if (in_read) begin
			result <= xor_value; // [RQ1]
		end
	end

	// accumulator: write-back or external load
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			ACC <= ACC_RESET;
		end else if (acc_update) begin
			ACC <= next_acc; // [RQ5]
		end
	end

	// register write strobe, only when the file is the destination
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			MEM_WR <= 1'b0;
		end else begin
			MEM_WR <= write_file; // [RQ5]
		end
	end

	// write data stays after the strobe for slow consumers
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			MEM_WDATA <= ACC_RESET;
		end else if (in_write) begin
			MEM_WDATA <= result; // [RQ5]
		end
	end

	// negative flag follows every result, whatever its destination
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			FLAG_N <= 1'b0;
		end else if (in_write) begin
			FLAG_N <= result_neg; // [RQ5]
		end
	end

	// zero flag follows every result, whatever its destination
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			FLAG_Z <= 1'b0;
		end else if (in_write) begin
			FLAG_Z <= result_zero; // [RQ5]
		end
	end

	// completion pulse, in step with the destination update
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			DONE <= 1'b0;
		end else begin
			DONE <= in_write;
		end
	end

	// busy covers every cycle a new request would be ignored
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			BUSY <= 1'b0;
		end else begin
			BUSY <= accept || in_read;
		end
	end
endmodule
`default_nettype wire

// File: verif/xor_acc_checker.sv
// timing and result checks for the xor datapath
`default_nettype none
module xor_acc_checker (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic MEM_RD,
	input wire logic MEM_WR,
	input wire logic DONE,
	input wire logic BUSY,
	input wire logic FLAG_N,
	input wire logic FLAG_Z,
	input wire logic [7:0] ACC,
	input wire logic [7:0] MEM_WDATA,
	input wire logic [7:0] MEM_RDATA
);
	wire logic [7:0] res;
	// result as seen at whichever destination took it
	assign res = MEM_WR ? MEM_WDATA : ACC;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	chk_read_done_gap: assert property (
		MEM_RD |=> !MEM_RD ##1 DONE) else $error("done off time");
	chk_xor_value: assert property (
		MEM_RD |-> ##2 res == ($past(ACC, 2) ^ $past(MEM_RDATA, 2)))
		else $error("bad xor");
	chk_write_done: assert property (
		MEM_WR |-> DONE) else $error("stray write");
	chk_acc_kept: assert property (
		DONE && MEM_WR |-> $stable(ACC)) else $error("acc hit");
	chk_flags_set: assert property (
		DONE |-> FLAG_Z == (res == 8'h00) && FLAG_N == res[7])
		else $error("bad flags");
	chk_busy_span: assert property (
		MEM_RD |-> BUSY ##1 BUSY ##1 !BUSY) else $error("busy span");
endmodule
bind xor_accumulator_with_file xor_acc_checker chk (.REF_CLK, .NRST,
	.MEM_RD, .MEM_WR, .DONE, .BUSY, .FLAG_N, .FLAG_Z, .ACC, .MEM_WDATA,
	.MEM_RDATA);
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the xor datapath
`default_nettype none
module testbench import xor_acc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, exec = 0, x = 0, ld = 0;
	logic [15:0] op = 0;
	logic [3:0] bank = 0;
	logic [11:0] ib = 0, a;
	logic [7:0] acc, r, f;
	logic [31:0] s = 91653;
	logic [21:0] q[$], e;
	int errors = 0, n_compared = 0;
	wire logic [11:0] ma;
	wire logic [7:0] rd, wd, accq;
	wire logic wr, done, fn, fz;
	// random source for every stimulus field
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// memory answers a pattern tied to the address
	assign rd = ma[7:0] ^ 8'h3C;
	xor_accumulator_with_file dut (.REF_CLK(clk), .NRST(rst_n),
		.EXEC(exec), .OPCODE(op), .XINST_EN(x), .BANK_SELECT_REG(bank),
		.INDEX_BASE(ib), .ACC_LOAD(ld), .ACC_IN(8'hA5), .MEM_RDATA(rd),
		.MEM_ADDR(ma), .MEM_RD(), .MEM_WR(wr), .MEM_WDATA(wd),
		.ACC(accq), .FLAG_N(fn), .FLAG_Z(fz), .BUSY(), .DONE(done));
	initial forever #5 clk = ~clk;
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// oldest note is matched mid-cycle, while done and results stand
	always @(negedge clk) if (done) begin
		e = q.pop_front();
		n_compared++;
		if ({ma, wr ? wd : accq, fn, fz} !== e) begin
			errors++;
			$display("wrong value op exp %h got %h", e,
				{ma, wr ? wd : accq, fn, fz});
		end
	end
	// ops start on field edges 5Eh..61h, then go random
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1;
		ld = 1;
		@(negedge clk);
		ld = 0;
		acc = 8'hA5;
		for (int i = 0; i < 200; i++) begin
			s = lfsr(s);
			f = i < 4 ? 8'h5E + i[7:0] : s[7:0];
			op = {OPC_XOR_FILE, s[9:8], f};
			x = s[10];
			bank = s[14:11];
			ib = s[26:15];
			if (s[8]) a = {bank, f};
			else if (f <= INDEXED_LIMIT) a = x ? ib + 12'(f) : {4'h0, f};
			else a = {ACCESS_HIGH_BANK, f};
			r = acc ^ a[7:0] ^ 8'h3C;
			if (!s[9]) acc = r;
			q.push_back({a, r, r[7], r == 8'h00});
			exec = 1;
			@(negedge clk);
			exec = 0;
			repeat (3) @(negedge clk);
		end
		repeat (4) @(negedge clk);
		end_of_test();
	end
	// cut a hang well past the expected span
	initial begin
		#20000;
		errors++;
		end_of_test();
	end
endmodule
`default_nettype wire
